// ===== design/bstps_top.sv
// boundary-scan tap with gpio pin sharing and test-mode pin handling
`timescale 1ns/1ps
// What this block does
// - holding the active-low test-mode pin low hands five shared pins to scan and idles the core.
// - clock, mode, data in, data out and test reset sit on gpio 0 to 4, back to gpio when high.
// - the tap controller and its registers follow the 2001 boundary-scan standard.
// - the decoder serves idcode, bypass, extest, sample, preload, highz and clamp.
// - under idcode a fixed identification word is shifted out.
module bstps_top
  import bstps_pkg::*;
#(
  parameter int FUNC_PINS = 8,
  parameter logic [31:0] IDCODE_VAL = BSTPS_IDCODE_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic test_mode_select_n,
  input wire logic gpio0_tck,
  input wire logic [4:1] gpio_pad_in,
  output logic [4:0] gpio_pad_out,
  output logic [4:0] gpio_pad_oe_n,
  input wire logic [4:0] core_gpio_out,
  input wire logic [4:0] core_gpio_oe_n,
  output logic [4:0] core_gpio_in,
  input wire logic [FUNC_PINS-1:0] func_pad_in,
  output logic [FUNC_PINS-1:0] func_pad_out,
  output logic [FUNC_PINS-1:0] func_pad_oe_n,
  input wire logic [FUNC_PINS-1:0] core_func_out,
  input wire logic [FUNC_PINS-1:0] core_func_oe_n,
  output logic [FUNC_PINS-1:0] core_func_in,
  output logic device_nonop
);
  localparam int SYNC_W = FUNC_PINS + BSTPS_GPIO_PINS + 1;

  // ---------------- system clock side ----------------
  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] s1_reg;
  logic [SYNC_W-1:0] s2_reg;
  logic [SYNC_W-1:0] s3_reg;
  logic [SYNC_W-1:0] filt_reg;
  logic [4:0] gpio_out_reg;
  logic [4:0] gpio_oe_n_reg;
  logic [FUNC_PINS-1:0] func_out_reg;
  logic [FUNC_PINS-1:0] func_oe_n_reg;
  logic test_mode;

  // bit 0 carries test mode as active high so every filter resets to zero
  assign raw_in = {func_pad_in, gpio_pad_in, gpio0_tck, ~test_mode_select_n};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
          s1_reg[gi] <= 1'b0;
          s2_reg[gi] <= 1'b0;
          s3_reg[gi] <= 1'b0;
        end else begin
          s1_reg[gi] <= raw_in[gi];
          s2_reg[gi] <= s1_reg[gi];
          s3_reg[gi] <= s2_reg[gi];
        end
      end
      // accept a change only once the last two stages agree
      always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
          filt_reg[gi] <= 1'b0;
        end else if (s2_reg[gi] == s3_reg[gi]) begin
          filt_reg[gi] <= s3_reg[gi];
        end
      end
    end
  endgenerate

  // filtered test mode idles the core
  assign test_mode = filt_reg[0];
  assign device_nonop = filt_reg[0];
  assign core_gpio_in = filt_reg[BSTPS_GPIO_PINS:1];
  assign core_func_in = filt_reg[SYNC_W-1:BSTPS_GPIO_PINS+1];

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      gpio_out_reg <= '0;
      gpio_oe_n_reg <= BSTPS_GPIO_OE_N_RST;
      func_out_reg <= '0;
      func_oe_n_reg <= '1;
    end else begin
      gpio_out_reg <= core_gpio_out;
      gpio_oe_n_reg <= core_gpio_oe_n;
      func_out_reg <= core_func_out;
      func_oe_n_reg <= core_func_oe_n;
    end
  end

  // ---------------- test clock side ----------------
  logic tap_rst_n;
  logic tms;
  logic tdi;
  logic [BSTPS_IR_LEN-1:0] ir_sr_reg;
  logic [BSTPS_IR_LEN-1:0] ir_reg;
  logic bypass_reg;
  logic [BSTPS_ID_LEN-1:0] id_sr_reg;
  logic tdo_reg;
  logic tdo_en_reg;
  logic sel_bsr;
  logic sel_id;
  logic sel_byp;
  logic drive_bsr;
  logic force_hiz;
  logic bsr_so;
  logic dr_so;
  logic tdo_next;
  logic [FUNC_PINS-1:0] upd_out;
  logic [FUNC_PINS-1:0] upd_oe_n;

  bstps_tap_if tap_bus ();

  // test reset or leaving test mode resets tap at once
  // raw pin on purpose: the tap must drop out even while clk_sys is stopped
  assign tap_rst_n = gpio_pad_in[BSTPS_PIN_TRST] & ~test_mode_select_n;
  // mode select and data in on gpio 1 and 2
  assign tms = gpio_pad_in[BSTPS_PIN_TMS];
  assign tdi = gpio_pad_in[BSTPS_PIN_TDI];

  bstps_tap_fsm u_fsm (
    .tck(gpio0_tck),
    .tap_rst_n(tap_rst_n),
    .tms(tms),
    .tap(tap_bus.ctrl)
  );

  assign sel_bsr = (ir_reg == BSTPS_IR_EXTEST) || (ir_reg == BSTPS_IR_SAMPLE)
                   || (ir_reg == BSTPS_IR_PRELOAD);
  assign sel_id = (ir_reg == BSTPS_IR_IDCODE);
  assign sel_byp = !sel_bsr && !sel_id;
  assign drive_bsr = (ir_reg == BSTPS_IR_EXTEST) || (ir_reg == BSTPS_IR_CLAMP);
  assign force_hiz = (ir_reg == BSTPS_IR_HIGHZ);

  // instruction shift with fixed capture pattern
  always_ff @(posedge gpio0_tck or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      ir_sr_reg <= BSTPS_IR_CAPTURE;
    end else if (tap_bus.capture_ir) begin
      ir_sr_reg <= BSTPS_IR_CAPTURE;
    end else if (tap_bus.shift_ir) begin
      ir_sr_reg <= {tdi, ir_sr_reg[BSTPS_IR_LEN-1:1]};
    end
  end

  // falling-edge load keeps the decode steady across the next rising edge
  // reset selects idcode
  always_ff @(negedge gpio0_tck or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      ir_reg <= BSTPS_IR_IDCODE;
    end else if (tap_bus.tlr) begin
      ir_reg <= BSTPS_IR_IDCODE;
    end else if (tap_bus.update_ir) begin
      ir_reg <= ir_sr_reg;
    end
  end

  always_ff @(posedge gpio0_tck or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      bypass_reg <= 1'b0;
    end else if (sel_byp && tap_bus.capture_dr) begin
      bypass_reg <= 1'b0;
    end else if (sel_byp && tap_bus.shift_dr) begin
      bypass_reg <= tdi;
    end
  end

  always_ff @(posedge gpio0_tck or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      id_sr_reg <= '0;
    end else if (sel_id && tap_bus.capture_dr) begin
      id_sr_reg <= IDCODE_VAL;
    end else if (sel_id && tap_bus.shift_dr) begin
      id_sr_reg <= {tdi, id_sr_reg[BSTPS_ID_LEN-1:1]};
    end
  end

  bstps_bsr #(
    .PINS(FUNC_PINS)
  ) u_bsr (
    .tck(gpio0_tck),
    .tap_rst_n(tap_rst_n),
    .tdi(tdi),
    .sel(sel_bsr),
    .tap(tap_bus.user),
    .pad_in(func_pad_in),
    .core_out(func_out_reg),
    .core_oe_n(func_oe_n_reg),
    .upd_out(upd_out),
    .upd_oe_n(upd_oe_n),
    .so(bsr_so)
  );

  assign dr_so = sel_bsr ? bsr_so : (sel_id ? id_sr_reg[0] : bypass_reg);
  // instruction scan wins over data scan at the output
  assign tdo_next = tap_bus.shift_ir ? ir_sr_reg[0] : dr_so;

  // data out moves on the falling edge, driven only while shifting
  always_ff @(negedge gpio0_tck or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      tdo_reg <= 1'b0;
      tdo_en_reg <= 1'b0;
    end else begin
      tdo_reg <= tdo_next;
      tdo_en_reg <= tap_bus.shift_ir || tap_bus.shift_dr;
    end
  end

  // ---------------- pad muxing ----------------
  // mux is static per mode, so a combinational select after the flops is safe
  // scan pins in test mode, gpio otherwise
  assign gpio_pad_out = test_mode ? {1'b0, tdo_reg, 3'h0} : gpio_out_reg;
  assign gpio_pad_oe_n = test_mode ? {1'b1, ~tdo_en_reg, 3'h7} : gpio_oe_n_reg;
  // extest and clamp drive from update cells, highz floats all
  assign func_pad_out = (test_mode && drive_bsr) ? upd_out : func_out_reg;
  assign func_pad_oe_n = (test_mode && force_hiz) ? '1 :
                         ((test_mode && drive_bsr) ? upd_oe_n : func_oe_n_reg);

  // ---------------- checks ----------------
  sequence s_test_low_four;
    (!test_mode_select_n) [*4];
  endsequence

  a_test_mode_entry: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_test_low_four |=> device_nonop)
    else $error("test mode held low but core not idled");

  a_pins_to_scan: assert property (@(posedge clk_sys) disable iff (!rst_b)
    test_mode |-> (gpio_pad_oe_n[2:0] == 3'h7) && gpio_pad_oe_n[4])
    else $error("scan input pins driven in test mode");

  a_pins_to_gpio: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !test_mode |-> (gpio_pad_out == gpio_out_reg) && (gpio_pad_oe_n == gpio_oe_n_reg))
    else $error("gpio pins not following core in normal mode");

  a_highz_floats: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (test_mode && (ir_reg == BSTPS_IR_HIGHZ)) |-> (func_pad_oe_n == '1))
    else $error("highz left a function pad driven");

  a_clamp_drives: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (test_mode && (ir_reg == BSTPS_IR_CLAMP))
      |-> (func_pad_out == upd_out) && (func_pad_oe_n == upd_oe_n))
    else $error("clamp pads not held from update cells");

  a_bypass_zero: assert property (@(posedge gpio0_tck) disable iff (!tap_rst_n)
    (tap_bus.capture_dr && sel_byp) |=> !bypass_reg)
    else $error("bypass did not capture zero");

  sequence s_id_capture_shift;
    (tap_bus.capture_dr && sel_id) ##1 tap_bus.shift_dr;
  endsequence

  a_idcode_shift: assert property (@(posedge gpio0_tck) disable iff (!tap_rst_n)
    s_id_capture_shift |=> (id_sr_reg[BSTPS_ID_LEN-2:0] == IDCODE_VAL[BSTPS_ID_LEN-1:1]))
    else $error("identification word not shifted");

  // checked on clk_sys since the test clock may stand still during reset
  a_trst_idcode: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !tap_rst_n |-> (ir_reg == BSTPS_IR_IDCODE) && tap_bus.tlr && !tdo_en_reg)
    else $error("test reset did not force reset state with idcode");

  sequence s_test_high_four;
    test_mode_select_n [*4];
  endsequence

  // the filter must let go as promptly as it takes hold
  a_test_mode_exit: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_test_high_four |=> !device_nonop)
    else $error("test mode released but core still idled");

  // only extest and clamp may steal the function pads, highz only floats them
  a_func_normal: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!test_mode || (!drive_bsr && !force_hiz))
      |-> (func_pad_out == func_out_reg) && (func_pad_oe_n == func_oe_n_reg))
    else $error("function pads left core control outside extest, clamp and highz");

  a_ir_capture: assert property (@(posedge gpio0_tck) disable iff (!tap_rst_n)
    tap_bus.capture_ir |=> (ir_sr_reg == BSTPS_IR_CAPTURE))
    else $error("instruction register did not capture fixed pattern");

  // update happens on the falling edge, so the rising edge after sees it
  a_ir_update: assert property (@(posedge gpio0_tck) disable iff (!tap_rst_n)
    tap_bus.update_ir |-> (ir_reg == ir_sr_reg))
    else $error("instruction not taken over in update-ir");

  // enable moves on the falling edge, so each rising edge must agree with the state
  a_tdo_enable: assert property (@(posedge gpio0_tck) disable iff (!tap_rst_n)
    tdo_en_reg == (tap_bus.shift_ir || tap_bus.shift_dr))
    else $error("data out enabled outside a shift state");

  a_bypass_shift: assert property (@(posedge gpio0_tck) disable iff (!tap_rst_n)
    (sel_byp && tap_bus.shift_dr) |=> (bypass_reg == $past(tdi)))
    else $error("bypass stage did not pass data in");
endmodule

// ===== design/bstps_pkg.sv
// shared constants and types for the boundary-scan port and its pin sharing
package bstps_pkg;
  localparam int BSTPS_IR_LEN = 4;
  localparam int BSTPS_GPIO_PINS = 5;
  localparam int BSTPS_ID_LEN = 32;
  localparam int BSTPS_BSR_CELLS_PER_PIN = 3;
  localparam int BSTPS_PIN_TCK = 0;
  localparam int BSTPS_PIN_TMS = 1;
  localparam int BSTPS_PIN_TDI = 2;
  localparam int BSTPS_PIN_TDO = 3;
  localparam int BSTPS_PIN_TRST = 4;
  localparam logic [3:0] BSTPS_IR_EXTEST = 4'h0;
  localparam logic [3:0] BSTPS_IR_SAMPLE = 4'h1;
  localparam logic [3:0] BSTPS_IR_PRELOAD = 4'h2;
  localparam logic [3:0] BSTPS_IR_IDCODE = 4'h3;
  localparam logic [3:0] BSTPS_IR_HIGHZ = 4'h4;
  localparam logic [3:0] BSTPS_IR_CLAMP = 4'h5;
  localparam logic [3:0] BSTPS_IR_BYPASS = 4'hF;
  localparam logic [3:0] BSTPS_IR_CAPTURE = 4'h1;
  // arbitrary identification word, lsb must stay 1
  localparam logic [31:0] BSTPS_IDCODE_DEFAULT = 32'h0A5C_3001;
  localparam logic [4:0] BSTPS_GPIO_OE_N_RST = 5'h1F;
  typedef enum logic [3:0] {
    ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR,
    ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
    ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } bstps_state_t;
endpackage

// ===== design/bstps_tap_if.sv
// state strobes from the tap controller to the register logic
`timescale 1ns/1ps
interface bstps_tap_if;
  logic tlr;
  logic capture_dr;
  logic shift_dr;
  logic update_dr;
  logic capture_ir;
  logic shift_ir;
  logic update_ir;
  modport ctrl (
    output tlr,
    output capture_dr,
    output shift_dr,
    output update_dr,
    output capture_ir,
    output shift_ir,
    output update_ir
  );
  modport user (
    input tlr,
    input capture_dr,
    input shift_dr,
    input update_dr,
    input capture_ir,
    input shift_ir,
    input update_ir
  );
endinterface

// ===== design/bstps_tap_fsm.sv
// sixteen-state tap controller on the test clock
`timescale 1ns/1ps
module bstps_tap_fsm
  import bstps_pkg::*;
(
  input wire logic tck,
  input wire logic tap_rst_n,
  input wire logic tms,
  bstps_tap_if.ctrl tap
);
  bstps_state_t state_reg;
  bstps_state_t state_next;

  always_ff @(posedge tck or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      state_reg <= ST_TLR;
    end else begin
      state_reg <= state_next;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_TLR: state_next = tms ? ST_TLR : ST_RTI;
      ST_RTI: state_next = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: state_next = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_next = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: state_next = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: state_next = tms ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: state_next = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: state_next = tms ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR: state_next = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: state_next = tms ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR: state_next = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: state_next = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: state_next = tms ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: state_next = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: state_next = tms ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR: state_next = tms ? ST_SEL_DR : ST_RTI;
      default: state_next = ST_TLR;
    endcase
  end

  assign tap.tlr = (state_reg == ST_TLR);
  assign tap.capture_dr = (state_reg == ST_CAP_DR);
  assign tap.shift_dr = (state_reg == ST_SHIFT_DR);
  assign tap.update_dr = (state_reg == ST_UPD_DR);
  assign tap.capture_ir = (state_reg == ST_CAP_IR);
  assign tap.shift_ir = (state_reg == ST_SHIFT_IR);
  assign tap.update_ir = (state_reg == ST_UPD_IR);

  sequence s_tms_five;
    tms [*5];
  endsequence

  a_tms_reset_walk: assert property (@(posedge tck) disable iff (!tap_rst_n)
    s_tms_five |=> tap.tlr)
    else $error("five tms highs did not reach reset state");

  a_capture_to_shift: assert property (@(posedge tck) disable iff (!tap_rst_n)
    (tap.capture_dr && !tms) |=> tap.shift_dr)
    else $error("capture-dr with tms low did not enter shift-dr");
endmodule

// ===== design/bstps_bsr.sv
// boundary register: input, output and enable cell per function pin
`timescale 1ns/1ps
module bstps_bsr
  import bstps_pkg::*;
#(
  parameter int PINS = 8
) (
  input wire logic tck,
  input wire logic tap_rst_n,
  input wire logic tdi,
  input wire logic sel,
  bstps_tap_if.user tap,
  input wire logic [PINS-1:0] pad_in,
  input wire logic [PINS-1:0] core_out,
  input wire logic [PINS-1:0] core_oe_n,
  output logic [PINS-1:0] upd_out,
  output logic [PINS-1:0] upd_oe_n,
  output logic so
);
  localparam int LEN = PINS * BSTPS_BSR_CELLS_PER_PIN;
  logic [LEN-1:0] sr_reg;
  logic [LEN-1:0] cap_vec;

  always_ff @(posedge tck or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      sr_reg <= '0;
    end else if (sel && tap.capture_dr) begin
      sr_reg <= cap_vec;
    end else if (sel && tap.shift_dr) begin
      sr_reg <= {tdi, sr_reg[LEN-1:1]};
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++) begin : g_cell
      assign cap_vec[BSTPS_BSR_CELLS_PER_PIN*gi] = pad_in[gi];
      assign cap_vec[BSTPS_BSR_CELLS_PER_PIN*gi+1] = core_out[gi];
      assign cap_vec[BSTPS_BSR_CELLS_PER_PIN*gi+2] = core_oe_n[gi];
      // update latches change on the falling edge so pins move glitch-free
      always_ff @(negedge tck or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
          upd_out[gi] <= 1'b0;
          upd_oe_n[gi] <= 1'b1;
        end else if (sel && tap.update_dr) begin
          upd_out[gi] <= sr_reg[BSTPS_BSR_CELLS_PER_PIN*gi+1];
          upd_oe_n[gi] <= sr_reg[BSTPS_BSR_CELLS_PER_PIN*gi+2];
        end
      end
    end
  endgenerate

  assign so = sr_reg[0];
endmodule

// ===== verification/bstps_scan_host.sv
// behavioural boundary-scan controller on the shared gpio pins
`timescale 1ns/1ps
module bstps_scan_host (
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_n,
  input wire logic tdo
);
  // clock stands low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b1;
  end

  // one step of the state graph, 64 ns period
  task automatic tick(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #32;
    q = tdo;
    tck = 1'b1;
    #32;
    tck = 1'b0;
  endtask

  task automatic tap_reset();
    logic q;
    trst_n = 1'b0;
    #40;
    trst_n = 1'b1;
    #24;
    tick(1'b0, 1'b0, q);
  endtask

  // instruction scan from idle back to idle
  task automatic ir_scan(input logic [3:0] ir, output logic [3:0] cap);
    logic q;
    tick(1'b1, 1'b0, q);
    tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
    tick(1'b0, 1'b0, q);
    for (int i = 0; i < 4; i++) begin
      tick(logic'(i == 3), ir[i], q);
      cap[i] = q;
    end
    tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
  endtask

  task automatic dr_scan(input int n, input logic [63:0] din, output logic [63:0] dout);
    logic q;
    dout = '0;
    tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
    tick(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      tick(logic'(i == n - 1), din[i], q);
      dout[i] = q;
    end
    tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
  endtask
endmodule

// ===== verification/bstps_top_tb.sv
// self-checking bench for the scan port and gpio pin sharing
`timescale 1ns/1ps
module bstps_top_tb;
  import bstps_pkg::*;
  localparam int NP = 2;
  // arbitrary identification word, lsb 1
  localparam logic [31:0] ID_EXP = 32'h5A3C_96E1;
  localparam logic [5:0] PRE = 6'h19;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  // pin starts low so its rise during reset gives the tap a clean reset edge
  logic test_mode_select_n = 1'b0;
  logic [4:0] core_gpio_out = 5'h0A;
  logic [4:0] core_gpio_oe_n = 5'h15;
  logic [NP-1:0] func_pad_in = 2'b10;
  logic [NP-1:0] core_func_out = 2'b01;
  logic [NP-1:0] core_func_oe_n = 2'b10;
  logic [4:0] gpio_pad_out;
  logic [4:0] gpio_pad_oe_n;
  logic [4:0] core_gpio_in;
  logic [NP-1:0] func_pad_out;
  logic [NP-1:0] func_pad_oe_n;
  logic [NP-1:0] core_func_in;
  logic device_nonop;
  logic tck, tms, tdi, trst_n;
  wire tdo_wire;
  int n_mismatch = 0;
  int n_checks = 0;
  logic [3:0] cap;
  logic [63:0] q;
  logic [3:0] codes [4] = '{BSTPS_IR_HIGHZ, BSTPS_IR_CLAMP, BSTPS_IR_BYPASS, 4'h9};

  always #10 clk_sys = ~clk_sys;

  // pulled-up line: released tdo reads high
  assign tdo_wire = gpio_pad_oe_n[3] ? 1'b1 : gpio_pad_out[3];

  bstps_scan_host host (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo_wire));

  bstps_top #(.FUNC_PINS(NP), .IDCODE_VAL(ID_EXP)) dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .test_mode_select_n(test_mode_select_n),
    .gpio0_tck(tck), .gpio_pad_in({trst_n, tdo_wire, tdi, tms}),
    .gpio_pad_out(gpio_pad_out), .gpio_pad_oe_n(gpio_pad_oe_n),
    .core_gpio_out(core_gpio_out), .core_gpio_oe_n(core_gpio_oe_n),
    .core_gpio_in(core_gpio_in), .func_pad_in(func_pad_in),
    .func_pad_out(func_pad_out), .func_pad_oe_n(func_pad_oe_n),
    .core_func_out(core_func_out), .core_func_oe_n(core_func_oe_n),
    .core_func_in(core_func_in), .device_nonop(device_nonop));

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask

  task automatic wait_nonop(input logic v);
    int k;
    for (k = 0; k < 20 && device_nonop !== v; k++) step(1);
    if (k == 20) begin
      n_mismatch++;
      conclude();
    end
  endtask

  task automatic t_normal();
    step(5);
    chk("gpio_in", core_gpio_in, {trst_n, tdo_wire, tdi, tms, tck});
    chk("func_in", core_func_in, func_pad_in);
    chk("gpio_out", gpio_pad_out, core_gpio_out);
    chk("gpio_oe_n", gpio_pad_oe_n, core_gpio_oe_n);
    chk("nonop_idle", device_nonop, 1'b0);
  endtask

  task automatic t_enter();
    test_mode_select_n = 1'b0;
    wait_nonop(1'b1);
    step(1);
    chk("nonop", device_nonop, 1'b1);
    chk("scan_oe_n", {gpio_pad_oe_n[4], gpio_pad_oe_n[2:0]}, 4'hF);
    chk("scan_out", {gpio_pad_out[4], gpio_pad_out[2:0]}, 4'h0);
  endtask

  task automatic t_idcode();
    host.tap_reset();
    host.dr_scan(32, 64'h0, q);
    chk("idcode", q[31:0], ID_EXP);
    host.ir_scan(BSTPS_IR_IDCODE, cap);
    chk("ir_capture", cap, BSTPS_IR_CAPTURE);
    host.dr_scan(32, 64'h0, q);
    chk("idcode_ir", q[31:0], ID_EXP);
  endtask

  task automatic t_boundary();
    logic [5:0] smp;
    for (int i = 0; i < NP; i++) smp[3*i +: 3] = {core_func_oe_n[i], core_func_out[i], func_pad_in[i]};
    host.ir_scan(BSTPS_IR_SAMPLE, cap);
    host.dr_scan(6, 64'h3F, q);
    chk("sample", q[5:0], smp);
    host.ir_scan(BSTPS_IR_PRELOAD, cap);
    host.dr_scan(6, {58'h0, PRE}, q);
    chk("preload_cap", q[5:0], smp);
    chk("pre_pads_oe", func_pad_oe_n, core_func_oe_n);
    host.ir_scan(BSTPS_IR_EXTEST, cap);
    #5;
    chk("extest_out", func_pad_out, {PRE[4], PRE[1]});
    chk("extest_oe", func_pad_oe_n, {PRE[5], PRE[2]});
  endtask

  task automatic t_bypass_like();
    foreach (codes[i]) begin
      host.ir_scan(codes[i], cap);
      host.dr_scan(2, 64'h3, q);
      chk("bypass_bits", q[1:0], 2'b10);
      if (codes[i] == BSTPS_IR_HIGHZ) chk("highz_oe", func_pad_oe_n, 2'b11);
      if (codes[i] == BSTPS_IR_CLAMP) chk("clamp_out", func_pad_out, {PRE[4], PRE[1]});
    end
  endtask

  task automatic t_trst();
    host.tap_reset();
    #5;
    chk("trst_pads", func_pad_oe_n, core_func_oe_n);
    host.dr_scan(32, 64'h0, q);
    chk("trst_id", q[31:0], ID_EXP);
  endtask

  task automatic t_exit();
    step(1);
    test_mode_select_n = 1'b1;
    core_gpio_out = 5'h15;
    core_gpio_oe_n = 5'h0A;
    // master reset pulsed as test mode is let go
    rst_b = 1'b0;
    step(2);
    rst_b = 1'b1;
    wait_nonop(1'b0);
    step(3);
    chk("back_out", gpio_pad_out, core_gpio_out);
    chk("back_oe_n", gpio_pad_oe_n, core_gpio_oe_n);
    chk("func_back", func_pad_out, core_func_out);
  endtask

  initial begin
    step(2);
    test_mode_select_n = 1'b1;
    step(18);
    rst_b = 1'b1;
    t_normal();
    t_enter();
    t_idcode();
    t_boundary();
    t_bypass_like();
    t_trst();
    t_exit();
    conclude();
  end

  initial begin
    #400000;
    n_mismatch++;
    conclude();
  end
endmodule
